// ### src/mcocfg_pkg.sv
// Purpose: Constants for the configuration option control block
// Assumes: Avalon-MM slave, byte-wide registers in low bits of 32-bit words
// Notes: Offsets are byte addresses; option store bit positions fixed here
package mcocfg_pkg;
    localparam logic [15:0] MCOCFG_WD_RESET_OFS = 16'h001d;
    localparam logic [15:0] MCOCFG_WD_CTRL_OFS = 16'h001e;
    localparam logic [15:0] MCOCFG_RUNTIME_OPT_OFS = 16'h3fdf;
    localparam logic [15:0] MCOCFG_ALT_WD_CLR_OFS = 16'h3ff0;
    localparam logic [15:0] MCOCFG_SECOND_OPT_OFS = 16'h3ff1;
    localparam logic [15:0] MCOCFG_PORTB_OPT_OFS = 16'h3ff2;
    localparam logic [15:0] MCOCFG_STATUS_OFS = 16'h3ff3;
    localparam logic [15:0] MCOCFG_PORTD_DIR_OFS = 16'h0007;
    localparam logic [15:0] MCOCFG_SPI_CTRL_OFS = 16'h000a;
    // Second option store fields
    localparam int MCOCFG_SO_ALT_BIT = 0;
    localparam int MCOCFG_SO_IRQ_BIT = 1;
    localparam int MCOCFG_SO_STOP_BIT = 2;
    localparam int MCOCFG_SO_WDE_BIT = 3;
    localparam int MCOCFG_SO_SEC_BIT = 4;
    // Runtime option register fields and SPI control wired-OR bit
    localparam int MCOCFG_RO_LOW_BIT = 0;
    localparam int MCOCFG_RO_HIGH_BIT = 1;
    localparam int MCOCFG_RO_IRQ_BIT = 7;
    localparam int MCOCFG_SPI_WOR_BIT = 5;
    // Memory ranges and register reset values
    localparam logic [15:0] MCOCFG_LOW_DUAL_LO = 16'h0020;
    localparam logic [15:0] MCOCFG_LOW_DUAL_HI = 16'h004f;
    localparam logic [15:0] MCOCFG_HIGH_DUAL_LO = 16'h0100;
    localparam logic [15:0] MCOCFG_HIGH_DUAL_HI = 16'h017f;
    localparam logic [15:0] MCOCFG_ALT_GAP_HI = 16'h0fff;
    localparam logic [7:0] MCOCFG_RUNTIME_RST = 8'h80;
    localparam logic [7:0] MCOCFG_ZERO8 = 8'h00;
endpackage

// ### src/mcocfg_top.sv
// Purpose: Mode selection and option decode for the configuration options
// Assumes: Option stores loaded by software over Avalon-MM (stand-in for
//          nonvolatile cells); i_por is a same-clock power-on reset level
// Notes: Watchdog, port, SPI and interrupt units live elsewhere
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mcocfg_top
    import mcocfg_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_por,
    input wire logic [ADDR_W-1:0] i_cpu_addr,
    input wire logic [7:0] i_portb_dir,
    input wire logic [7:0] i_portd_dir,
    input wire logic i_spi_mosi_oe_req,
    input wire logic i_spi_miso_oe_req,
    input wire logic i_spi_sck_oe_req,
    input wire logic i_wd_timeout,
    input wire logic i_clkmon_timeout,
    input wire logic i_stop_entry,
    output logic o_alt_mode,
    output logic o_addr_disabled,
    output logic o_low_dual_ram,
    output logic o_high_dual_ram,
    output logic [7:0] o_portd_dir_eff,
    output logic o_spi_mosi_oe,
    output logic o_spi_miso_oe,
    output logic o_spi_sck_oe,
    output logic o_portd_wired_or,
    output logic o_reset_pin_o,
    output logic o_reset_pin_oe,
    output logic [7:0] o_portb_pullup,
    output logic [7:0] o_portb_int_en,
    output logic o_irq_edge_level,
    output logic o_clkmon_on_stop,
    output logic o_alt_wd_enable,
    output logic o_alt_wd_clear,
    output logic o_security_block
);
    // The decode compares 16-bit offsets, so a narrower bus cannot work
    if (ADDR_W < 16) begin : g_addr_chk
        $error("ADDR_W must be at least 16");
    end

    logic [7:0] second_store_q, portb_store_q, runtime_q, spi_ctrl_q;
    logic [7:0] wd_reset_q, wd_ctrl_q, portd_dir_q;
    logic irq_armed_q, ack_q, alt_wd_clear_q;
    logic [15:0] a16;
    logic wr_acc, rd_acc, alt;

    assign a16 = i_avs_address[15:0];
    assign alt = second_store_q[MCOCFG_SO_ALT_BIT] & ~i_por;
    // One wait state per access; the acknowledge cycle drops waitrequest
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_acc = i_avs_write & ack_q & i_ce & i_avs_byteenable[0];
    // Read data is captured while waitrequest is still high, so it already
    // stands at the edge where the master sees waitrequest low
    assign rd_acc = i_avs_read & ~ack_q & i_ce;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else if (i_ce) begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            second_store_q <= MCOCFG_ZERO8;
            portb_store_q <= MCOCFG_ZERO8;
            spi_ctrl_q <= MCOCFG_ZERO8;
        end else if (wr_acc) begin
            if (a16 == MCOCFG_SECOND_OPT_OFS)
                second_store_q <= i_avs_writedata[7:0];
            if (a16 == MCOCFG_PORTB_OPT_OFS)
                portb_store_q <= i_avs_writedata[7:0];
            if (a16 == MCOCFG_SPI_CTRL_OFS)
                spi_ctrl_q <= i_avs_writedata[7:0];
        end
    end

    // Watchdog registers and direction register exist in primary mode only
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wd_reset_q <= MCOCFG_ZERO8;
            wd_ctrl_q <= MCOCFG_ZERO8;
            portd_dir_q <= MCOCFG_ZERO8;
        end else if (wr_acc && !alt) begin
            if (a16 == MCOCFG_WD_RESET_OFS)
                wd_reset_q <= i_avs_writedata[7:0];
            if (a16 == MCOCFG_WD_CTRL_OFS)
                wd_ctrl_q <= i_avs_writedata[7:0];
            if (a16 == MCOCFG_PORTD_DIR_OFS)
                portd_dir_q <= i_avs_writedata[7:0];
        end
    end

    // Runtime option register; the sensitivity bit takes a single write
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            runtime_q <= MCOCFG_RUNTIME_RST;
            irq_armed_q <= 1'b1;
        end else if (wr_acc && !alt && a16 == MCOCFG_RUNTIME_OPT_OFS) begin
            runtime_q[MCOCFG_RO_LOW_BIT] <=
                i_avs_writedata[MCOCFG_RO_LOW_BIT];
            runtime_q[MCOCFG_RO_HIGH_BIT] <=
                i_avs_writedata[MCOCFG_RO_HIGH_BIT];
            if (irq_armed_q) begin
                runtime_q[MCOCFG_RO_IRQ_BIT] <=
                    i_avs_writedata[MCOCFG_RO_IRQ_BIT];
                irq_armed_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            alt_wd_clear_q <= 1'b0;
        end else if (i_ce) begin
            alt_wd_clear_q <= wr_acc & alt
                & (a16 == MCOCFG_ALT_WD_CLR_OFS);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            o_avs_readdata <= 32'h0000_0000;
            case (a16)
                MCOCFG_SECOND_OPT_OFS:
                    o_avs_readdata[7:0] <= second_store_q;
                MCOCFG_PORTB_OPT_OFS:
                    o_avs_readdata[7:0] <= portb_store_q;
                MCOCFG_SPI_CTRL_OFS:
                    o_avs_readdata[7:0] <= spi_ctrl_q;
                MCOCFG_RUNTIME_OPT_OFS:
                    o_avs_readdata[7:0] <= alt ? 8'h00 : runtime_q;
                MCOCFG_WD_RESET_OFS:
                    o_avs_readdata[7:0] <= alt ? 8'h00 : wd_reset_q;
                MCOCFG_WD_CTRL_OFS:
                    o_avs_readdata[7:0] <= alt ? 8'h00 : wd_ctrl_q;
                MCOCFG_PORTD_DIR_OFS:
                    o_avs_readdata[7:0] <= alt ? 8'h00 : portd_dir_q;
                MCOCFG_STATUS_OFS:
                    o_avs_readdata[7:0] <= {6'h00, irq_armed_q, alt};
                default:
                    o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    logic nv_irq, runtime_irq;
    assign nv_irq = alt & second_store_q[MCOCFG_SO_IRQ_BIT];
    assign runtime_irq = runtime_q[MCOCFG_RO_IRQ_BIT];

    assign o_alt_mode = alt;
    assign o_addr_disabled = alt & (i_cpu_addr[15:0] >= MCOCFG_HIGH_DUAL_LO)
        & (i_cpu_addr[15:0] <= MCOCFG_ALT_GAP_HI);
    // Low region is fixed EPROM in alternate mode
    assign o_low_dual_ram = ~alt & runtime_q[MCOCFG_RO_LOW_BIT];
    assign o_high_dual_ram = ~alt & runtime_q[MCOCFG_RO_HIGH_BIT];
    assign o_portd_dir_eff = alt ? 8'h00 : portd_dir_q;
    assign o_spi_mosi_oe = i_spi_mosi_oe_req
        & (alt | portd_dir_q[3]);
    assign o_spi_miso_oe = i_spi_miso_oe_req & (alt | portd_dir_q[2]);
    assign o_spi_sck_oe = i_spi_sck_oe_req & (alt | portd_dir_q[4]);
    assign o_portd_wired_or = ~alt & spi_ctrl_q[MCOCFG_SPI_WOR_BIT];
    assign o_reset_pin_o = 1'b0;
    assign o_reset_pin_oe = ~alt
        & (i_wd_timeout | i_clkmon_timeout | i_por);
    generate
        for (genvar b = 0; b < 8; b++) begin : g_pb
            assign o_portb_pullup[b] = portb_store_q[b] & ~i_portb_dir[b];
            assign o_portb_int_en[b] = portb_store_q[b] & ~i_portb_dir[b];
        end
    endgenerate
    assign o_irq_edge_level = alt ? nv_irq : runtime_irq;
    assign o_clkmon_on_stop = alt & second_store_q[MCOCFG_SO_STOP_BIT]
        & i_stop_entry;
    assign o_alt_wd_enable = alt & second_store_q[MCOCFG_SO_WDE_BIT];
    assign o_alt_wd_clear = alt_wd_clear_q;
    assign o_security_block = second_store_q[MCOCFG_SO_SEC_BIT];

    a_por_primary: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_por |-> !o_alt_mode && o_reset_pin_oe)
        else $error("power-on reset did not force primary mode");
    a_alt_no_reset_drive: assert property (@(posedge i_core_clk)
        disable iff (i_rst) o_alt_mode |-> !o_reset_pin_oe)
        else $error("reset pin driven in alternate mode");
    a_irq_write_once: assert property (@(posedge i_core_clk)
        disable iff (i_rst) !irq_armed_q |=> $stable(runtime_q[7]))
        else $error("sensitivity changed after its single write");
    a_gap_disabled: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_alt_mode && i_cpu_addr[15:0] == 16'h0800) |-> o_addr_disabled)
        else $error("gap address not disabled");
    a_wd_forced_zero: assert property (@(posedge i_core_clk)
        disable iff (i_rst) !o_alt_mode |-> !o_alt_wd_enable)
        else $error("watchdog enable not forced in primary");
    a_clear_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_alt_wd_clear |=> !o_alt_wd_clear)
        else $error("clear pulse longer than one cycle");
    a_wor_alt_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_alt_mode |-> !o_portd_wired_or && o_portd_dir_eff == 8'h00)
        else $error("port D controls active in alternate mode");
    a_nv_irq_primary: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        !o_alt_mode |-> o_irq_edge_level == runtime_q[7])
        else $error("sensitivity source wrong in primary");

    // Bus-side events that the multi-step checks start from
    sequence s_alt_clear_write;
        wr_acc && alt && (a16 == MCOCFG_ALT_WD_CLR_OFS);
    endsequence

    sequence s_runtime_write;
        wr_acc && !alt && (a16 == MCOCFG_RUNTIME_OPT_OFS);
    endsequence

    sequence s_alt_write;
        wr_acc && alt;
    endsequence

    // A clear written in alternate mode shows as a pulse next cycle
    a_clear_after_write: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        s_alt_clear_write |=> o_alt_wd_clear)
        else $error("clear write did not pulse the watchdog clear");

    // In primary mode the clear register does nothing at all
    a_clear_primary_off: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (!$past(alt) && $past(i_ce)) |-> !o_alt_wd_clear)
        else $error("watchdog clear pulsed in primary mode");

    // Any primary-mode runtime write uses up the single sensitivity write
    a_irq_write_used: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        s_runtime_write |=> !irq_armed_q)
        else $error("sensitivity write did not disarm");

    // Primary watchdog registers ignore writes in alternate mode
    a_wd_regs_frozen: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        s_alt_write |=> $stable(wd_ctrl_q) && $stable(wd_reset_q))
        else $error("watchdog register written in alternate mode");

    // Direction register ignores writes in alternate mode
    a_dir_frozen_alt: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        s_alt_write |=> $stable(portd_dir_q))
        else $error("direction register written in alternate mode");

    // Runtime option register ignores writes in alternate mode
    a_runtime_frozen_alt: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        s_alt_write |=> $stable(runtime_q))
        else $error("runtime option written in alternate mode");

    // Option-store sensitivity never leaks into primary mode
    a_nv_irq_forced: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        !o_alt_mode |-> !nv_irq)
        else $error("option-store sensitivity active in primary");

    // Stop-disable has no effect in primary mode
    a_stop_forced: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        !o_alt_mode |-> !o_clkmon_on_stop)
        else $error("clock monitor armed on stop in primary");

    // Dual regions are never RAM in alternate mode
    a_dual_eprom_alt: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        o_alt_mode |-> !o_low_dual_ram && !o_high_dual_ram)
        else $error("dual region mapped to RAM in alternate mode");

    // Pullup and interrupt go together and only on input bits
    a_pb_pair: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (o_portb_pullup == o_portb_int_en)
        && ((o_portb_pullup & i_portb_dir) == 8'h00))
        else $error("port B pullup and interrupt disagree");

    // A cleared direction bit keeps the SPI output quiet in primary
    a_spi_gated: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (!o_alt_mode && !portd_dir_q[3]) |-> !o_spi_mosi_oe)
        else $error("SPI output driven without direction bit");

    // Alternate mode lets the SPI drive with no direction bit
    a_spi_free_alt: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (o_alt_mode && i_spi_sck_oe_req) |-> o_spi_sck_oe)
        else $error("SPI clock output blocked in alternate mode");

    // A watchdog timeout pulls the reset pin low in primary mode
    a_reset_drive_wd: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (!o_alt_mode && i_wd_timeout) |-> o_reset_pin_oe && !o_reset_pin_o)
        else $error("reset pin not driven on watchdog timeout");

    // Addresses below the gap stay usable in alternate mode
    a_gap_lower_edge: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (o_alt_mode && i_cpu_addr[15:0] < MCOCFG_HIGH_DUAL_LO)
        |-> !o_addr_disabled)
        else $error("address below the gap disabled");

    // Primary mode keeps the whole map
    a_primary_full_map: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        !o_alt_mode |-> !o_addr_disabled)
        else $error("address disabled in primary mode");
endmodule
`default_nettype wire

// ### test/mcocfg_tb.sv
// Purpose: Self-checking bench for the configuration option control block
// Assumes: Read data is registered one edge before the acknowledging edge
// Notes: Option stores are loaded over the bus in place of nonvolatile cells
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("wrong value at %0t: %h %h", $time, got, exp); \
        end \
    end
module tb;
    import mcocfg_pkg::*;
    logic i_core_clk, i_rst, i_avs_read, i_avs_write, i_por;
    logic i_spi_mosi_oe_req, i_spi_miso_oe_req, i_spi_sck_oe_req;
    logic i_wd_timeout, i_clkmon_timeout, i_stop_entry;
    logic [15:0] i_avs_address, i_cpu_addr;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [7:0] i_portb_dir, i_portd_dir, o_portd_dir_eff, rd_q;
    logic [7:0] o_portb_pullup, o_portb_int_en;
    logic o_avs_waitrequest, o_alt_mode, o_addr_disabled, o_low_dual_ram;
    logic o_high_dual_ram, o_spi_mosi_oe, o_spi_miso_oe, o_spi_sck_oe;
    logic o_portd_wired_or, o_reset_pin_o, o_reset_pin_oe, o_irq_edge_level;
    logic o_clkmon_on_stop, o_alt_wd_enable, o_alt_wd_clear, o_security_block;
    int fail_count = 0;
    int n_compared = 0;

    mcocfg_top dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(4'h1), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_por(i_por),
        .i_cpu_addr(i_cpu_addr), .i_portb_dir(i_portb_dir),
        .i_portd_dir(i_portd_dir), .i_spi_mosi_oe_req(i_spi_mosi_oe_req),
        .i_spi_miso_oe_req(i_spi_miso_oe_req),
        .i_spi_sck_oe_req(i_spi_sck_oe_req), .i_wd_timeout(i_wd_timeout),
        .i_clkmon_timeout(i_clkmon_timeout), .i_stop_entry(i_stop_entry),
        .o_alt_mode(o_alt_mode), .o_addr_disabled(o_addr_disabled),
        .o_low_dual_ram(o_low_dual_ram), .o_high_dual_ram(o_high_dual_ram),
        .o_portd_dir_eff(o_portd_dir_eff), .o_spi_mosi_oe(o_spi_mosi_oe),
        .o_spi_miso_oe(o_spi_miso_oe), .o_spi_sck_oe(o_spi_sck_oe),
        .o_portd_wired_or(o_portd_wired_or), .o_reset_pin_o(o_reset_pin_o),
        .o_reset_pin_oe(o_reset_pin_oe), .o_portb_pullup(o_portb_pullup),
        .o_portb_int_en(o_portb_int_en), .o_irq_edge_level(o_irq_edge_level),
        .o_clkmon_on_stop(o_clkmon_on_stop), .o_alt_wd_enable(o_alt_wd_enable),
        .o_alt_wd_clear(o_alt_wd_clear), .o_security_block(o_security_block));

    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    task automatic bus(input logic wr, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge i_core_clk);
        i_avs_address <= a;
        i_avs_writedata <= {24'h000000, d};
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        // Hold the request until waitrequest is sampled low at a rising edge
        do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
        rd_q = o_avs_readdata[7:0];
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        // Outputs are compared once the write has settled
        @(negedge i_core_clk);
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #200us;
        fail_count++;
        report_and_stop();
    end

    initial begin
        {i_avs_read, i_avs_write, i_por, i_wd_timeout, i_stop_entry} = '0;
        {i_spi_mosi_oe_req, i_spi_miso_oe_req, i_spi_sck_oe_req} = 3'h7;
        i_clkmon_timeout = 1'b0;
        i_avs_address = 16'h0000;
        i_avs_writedata = 32'h00000000;
        i_cpu_addr = 16'h0800;
        i_portb_dir = 8'h0f;
        i_portd_dir = 8'h00;
        i_rst = 1'b1;
        repeat (10) @(posedge i_core_clk);
        i_rst <= 1'b0;
        bus(1'b0, MCOCFG_RUNTIME_OPT_OFS, 8'h00);
        `CHK(rd_q, 8'h80)
        `CHK(o_addr_disabled, 1'b0)
        bus(1'b1, MCOCFG_SECOND_OPT_OFS, 8'h0e);
        `CHK({o_alt_mode, o_irq_edge_level, o_alt_wd_enable}, 3'h2)
        bus(1'b1, MCOCFG_RUNTIME_OPT_OFS, 8'h03);
        `CHK({o_low_dual_ram, o_high_dual_ram, o_irq_edge_level}, 3'h6)
        bus(1'b1, MCOCFG_RUNTIME_OPT_OFS, 8'h80);
        bus(1'b0, MCOCFG_RUNTIME_OPT_OFS, 8'h00);
        `CHK(rd_q, 8'h00)
        bus(1'b1, MCOCFG_PORTD_DIR_OFS, 8'h14);
        `CHK(o_portd_dir_eff, 8'h14)
        `CHK({o_spi_mosi_oe, o_spi_miso_oe, o_spi_sck_oe}, 3'h3)
        bus(1'b1, MCOCFG_SPI_CTRL_OFS, 8'h20);
        `CHK(o_portd_wired_or, 1'b1)
        @(posedge i_core_clk);
        i_stop_entry <= 1'b1;
        i_wd_timeout <= 1'b1;
        @(negedge i_core_clk);
        `CHK({o_reset_pin_oe, o_reset_pin_o, o_clkmon_on_stop}, 3'h4)
        @(posedge i_core_clk);
        i_wd_timeout <= 1'b0;
        i_clkmon_timeout <= 1'b1;
        @(negedge i_core_clk);
        `CHK(o_reset_pin_oe, 1'b1)
        bus(1'b1, MCOCFG_ALT_WD_CLR_OFS, 8'h01);
        `CHK(o_alt_wd_clear, 1'b0)
        bus(1'b1, MCOCFG_SECOND_OPT_OFS, 8'h1f);
        `CHK({o_alt_mode, o_irq_edge_level, o_alt_wd_enable}, 3'h7)
        `CHK({o_clkmon_on_stop, o_security_block}, 2'h3)
        `CHK({o_reset_pin_oe, o_portd_wired_or}, 2'h0)
        `CHK(o_portd_dir_eff, 8'h00)
        `CHK({o_spi_mosi_oe, o_spi_miso_oe, o_spi_sck_oe}, 3'h7)
        `CHK(o_addr_disabled, 1'b1)
        @(posedge i_core_clk);
        i_cpu_addr <= 16'h1000;
        @(negedge i_core_clk);
        `CHK(o_addr_disabled, 1'b0)
        bus(1'b0, MCOCFG_WD_CTRL_OFS, 8'h00);
        `CHK(rd_q, 8'h00)
        bus(1'b1, MCOCFG_ALT_WD_CLR_OFS, 8'h01);
        `CHK(o_alt_wd_clear, 1'b1)
        bus(1'b1, MCOCFG_PORTB_OPT_OFS, 8'ha5);
        `CHK({o_portb_pullup, o_portb_int_en}, 16'ha0a0)
        bus(1'b0, 16'h2000, 8'h00);
        `CHK(rd_q, 8'h00)
        @(posedge i_core_clk);
        i_por <= 1'b1;
        @(negedge i_core_clk);
        `CHK({o_alt_mode, o_irq_edge_level, o_alt_wd_enable}, 3'h0)
        report_and_stop();
    end
endmodule
`default_nettype wire
